//--- design/pust_pkg.sv
/*
 * package for the power-up strap capture and test-mode decode block.
 * assumes a single 100 mhz reference clock; pci rate derived by enable.
 */
package pust_pkg;
	// pci clock enable from 100 mhz: accumulate 33 per 100
	localparam int unsigned REF_CLK_MHZ      = 100;
	localparam int unsigned PCI_CLK_MHZ      = 33;
	localparam logic [7:0]  PCI_ACC_STEP     = 8'(PCI_CLK_MHZ);
	localparam logic [7:0]  PCI_ACC_WRAP     = 8'(REF_CLK_MHZ);
	// low-time count decode thresholds, in pci clocks
	localparam logic [5:0]  TM_NAND1_CNT     = 6'h04;
	localparam logic [5:0]  TM_NAND4_CNT     = 6'h07;
	localparam logic [5:0]  TM_ALLZ_CNT      = 6'h08;
	localparam logic [5:0]  TM_RSV_LO_CNT    = 6'h0A;
	localparam logic [5:0]  TM_RSV_HI_CNT    = 6'h18;
	localparam logic [5:0]  TM_CNT_SAT       = 6'h3F;
	// status bit positions in the bridge config word at d4h
	localparam logic [7:0]  CFG_STRAP_OFFSET = 8'hD4;
	localparam int unsigned NO_REBOOT_BIT    = 1;
	localparam int unsigned SAFE_MODE_BIT    = 2;
	// reset values of the tone and link pin synchronisers (pull levels)
	localparam logic        TONE_RST_VAL     = 1'b1;
	localparam logic        LINK_RST_VAL     = 1'b0;

	typedef enum logic [2:0] {
		PUST_TM_NONE  = 3'b000,
		PUST_TM_NAND1 = 3'b001,
		PUST_TM_NAND2 = 3'b010,
		PUST_TM_NAND3 = 3'b011,
		PUST_TM_NAND4 = 3'b100,
		PUST_TM_ALLZ  = 3'b101
	} pust_tmode_t;

	typedef struct packed {
		logic reboot_inhibit;
		logic safe_mode;
	} pust_straps_t;
endpackage : pust_pkg

//--- design/pust_sync.sv
/*
 * two-flop synchroniser for pin inputs.
 * assumes the pin may change at any time relative to i_ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module pust_sync (
	// clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_rst,
	input  wire logic i_rst_val,
	// pin in, synchronised out
	input  wire logic i_async,
	output logic      o_sync
);
	logic meta_reg;

	// first stage read only by second stage
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			meta_reg <= i_rst_val;
			o_sync   <= i_rst_val;
		end else begin
			meta_reg <= i_async;
			o_sync   <= meta_reg;
		end
	end
endmodule : pust_sync
`default_nettype wire

//--- design/pust_top.sv
/*
 * power-up strap capture and factory test-mode decode.
 * assumes strap pins settle before power-good rises and that
 * board pull resistors are modelled outside this block.
 */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1: capture straps on power-good rise, release pins
// RULE2: board holds strap four pci clocks before
// RULE3: tone strap low inhibits watchdog reboot
// RULE4: reboot-inhibit status readable at d4h bit1
// RULE5: link strap high forces safe cpu straps
// RULE6: safe-mode status readable at d4h bit2
// RULE7: count pci clocks reset low, power good
// RULE8: decode count into nand, all-z or none
// RULE9: tester pulls reset low after host reset
// RULE10: hold captured straps until next rise
// RULE11: no reserved modes; decode after reset release
module pust_top (
	// clock and reset
	input  wire logic                 i_ref_clk,
	input  wire logic                 i_rst,
	// pins
	input  wire logic                 i_power_good_in,
	input  wire logic                 i_tone_output_pin,
	input  wire logic                 i_codec_link_serial_out,
	input  wire logic                 i_battery_well_reset_n,
	input  wire logic                 i_host_bus_reset_n,
	// strap results
	output pust_pkg::pust_straps_t    o_straps,
	output logic [7:0]                o_cfg_d4_status,
	output logic                      o_watchdog_reboot_en,
	output logic                      o_cpu_safe_straps,
	output logic                      o_strap_pins_released,
	// test mode
	output pust_pkg::pust_tmode_t     o_test_mode,
	output logic                      o_all_outputs_hiz
);
	import pust_pkg::*;

	logic        pg_sync;
	logic        tone_sync;
	logic        link_sync;
	logic        rtc_n_sync;
	logic        hrst_n_sync;
	logic        pg_prev_reg;
	logic        pg_rise;
	logic [7:0]  acc_reg;
	logic        pci_en;
	logic [5:0]  low_cnt_reg;
	logic        rtc_prev_reg;
	logic        low_seen_reg;
	logic        rel_reg;
	pust_straps_t straps_reg;
	pust_tmode_t  tmode_reg;

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	pust_sync u_pg   (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_rst_val(1'b0),
		.i_async(i_power_good_in), .o_sync(pg_sync));
	pust_sync u_tone (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_rst_val(TONE_RST_VAL),
		.i_async(i_tone_output_pin), .o_sync(tone_sync));
	pust_sync u_link (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_rst_val(LINK_RST_VAL),
		.i_async(i_codec_link_serial_out), .o_sync(link_sync));
	pust_sync u_rtc  (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_rst_val(1'b1),
		.i_async(i_battery_well_reset_n), .o_sync(rtc_n_sync));
	pust_sync u_hrst (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_rst_val(1'b0),
		.i_async(i_host_bus_reset_n), .o_sync(hrst_n_sync));

	// ************************************************************
	// strap capture
	// ************************************************************

	// edge detect on the synchronised power-good only
	always_ff @(posedge i_ref_clk) begin
		if (i_rst)
			pg_prev_reg <= 1'b0;
		else
			pg_prev_reg <= pg_sync;
	end
	assign pg_rise = pg_sync & ~pg_prev_reg;

	// straps move only on a rise; later pin activity ignored
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			straps_reg <= '0;
		end else if (pg_rise) begin // see RULE1 see RULE10
			straps_reg.reboot_inhibit <= ~tone_sync; // see RULE3
			straps_reg.safe_mode      <= link_sync;  // see RULE5
		end
	end

	// pins go back to normal function after sampling; sync lag
	// means the board must hold levels a few clocks, see RULE2
	always_ff @(posedge i_ref_clk) begin
		if (i_rst)
			rel_reg <= 1'b0;
		else if (!pg_sync)
			rel_reg <= 1'b0;
		else if (pg_rise)
			rel_reg <= 1'b1; // see RULE1
	end

	assign o_straps              = straps_reg;
	assign o_strap_pins_released = rel_reg;
	assign o_watchdog_reboot_en  = ~straps_reg.reboot_inhibit; // see RULE3
	assign o_cpu_safe_straps     = straps_reg.safe_mode;       // see RULE5

	// status word: other bits read zero
	always_comb begin
		o_cfg_d4_status                = 8'h00;
		o_cfg_d4_status[NO_REBOOT_BIT] = straps_reg.reboot_inhibit; // see RULE4
		o_cfg_d4_status[SAFE_MODE_BIT] = straps_reg.safe_mode;      // see RULE6
	end

	// ************************************************************
	// pci-rate enable and low-time counter
	// ************************************************************

	// fractional divider: 33 enables per 100 ref clocks, jitter accepted
	// restart the phase on the first low cycle of a pulse, so a low time
	// of n pci periods counts n rather than n-1 or n by chance
	always_ff @(posedge i_ref_clk) begin
		if (i_rst)
			acc_reg <= 8'h00;
		else if (!rtc_n_sync && rtc_prev_reg)
			acc_reg <= PCI_ACC_STEP; // see RULE7
		else if (acc_reg + PCI_ACC_STEP >= PCI_ACC_WRAP)
			acc_reg <= 8'(acc_reg + PCI_ACC_STEP - PCI_ACC_WRAP);
		else
			acc_reg <= 8'(acc_reg + PCI_ACC_STEP);
	end
	assign pci_en = (acc_reg + PCI_ACC_STEP >= PCI_ACC_WRAP);

	// count only with power good and host reset released, see RULE9
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || !pg_sync) begin
			low_cnt_reg  <= 6'h00;
			low_seen_reg <= 1'b0;
		end else if (!rtc_n_sync && hrst_n_sync) begin
			low_seen_reg <= 1'b1;
			if (rtc_prev_reg)
				low_cnt_reg <= 6'h00; // first low cycle starts from zero
			else if (pci_en && low_cnt_reg != TM_CNT_SAT)
				low_cnt_reg <= 6'(low_cnt_reg + 6'h01); // see RULE7
		end else if (rtc_n_sync) begin
			low_seen_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst)
			rtc_prev_reg <= 1'b1;
		else
			rtc_prev_reg <= rtc_n_sync;
	end

	// ************************************************************
	// test-mode decode
	// ************************************************************
	function automatic pust_tmode_t decode_tm(input logic [5:0] cnt);
		if (cnt >= TM_NAND1_CNT && cnt <= TM_NAND4_CNT)
			decode_tm = pust_tmode_t'(3'(cnt - TM_NAND1_CNT + 6'h01));
		else if (cnt == TM_ALLZ_CNT)
			decode_tm = PUST_TM_ALLZ;
		else
			decode_tm = PUST_TM_NONE; // reserved counts land here too
	endfunction : decode_tm

	// evaluated at reset release; power-good low clears it
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || !pg_sync)
			tmode_reg <= PUST_TM_NONE;
		else if (rtc_n_sync && low_seen_reg)
			tmode_reg <= decode_tm(low_cnt_reg); // see RULE8 see RULE11
	end

	assign o_test_mode       = tmode_reg;
	assign o_all_outputs_hiz = (tmode_reg == PUST_TM_ALLZ);

	// ************************************************************
	// checks
	// ************************************************************
	// capture, status, counting and decode checks
	straps_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RULE10
		!pg_rise |=> $stable(straps_reg)) else $error("straps moved without rise");
	tone_capture_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RULE3
		pg_rise |=> straps_reg.reboot_inhibit == !$past(tone_sync))
		else $error("tone strap capture wrong");
	link_capture_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RULE5
		pg_rise |=> o_cpu_safe_straps == $past(link_sync))
		else $error("safe strap capture wrong");
	status_bits_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RULE4
		o_cfg_d4_status[1] == !o_watchdog_reboot_en && o_cfg_d4_status[2] == o_straps.safe_mode)
		else $error("status bits mismatch");
	no_reserved_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RULE11
		(rtc_n_sync && low_seen_reg && pg_sync && low_cnt_reg >= TM_RSV_LO_CNT)
		|=> tmode_reg == PUST_TM_NONE) else $error("reserved count entered mode");
	nand_decode_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RULE8
		(rtc_n_sync && low_seen_reg && pg_sync && low_cnt_reg == 6'h05)
		|=> tmode_reg == PUST_TM_NAND2) else $error("count 5 not nand 2");
	stable_low_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RULE11
		(!rtc_n_sync && rtc_prev_reg && pg_sync) |=> $stable(tmode_reg))
		else $error("mode changed while reset low");
	count_pwr_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RULE7
		!pg_sync |=> low_cnt_reg == 6'h00) else $error("count without power good");
	release_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RULE1
		pg_rise |=> o_strap_pins_released) else $error("pins not released");

	// counting and decode checks
	allz_decode_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RULE8
		(rtc_n_sync && low_seen_reg && pg_sync && low_cnt_reg == TM_ALLZ_CNT)
		|=> tmode_reg == PUST_TM_ALLZ) else $error("count 8 not all-z");
	first_low_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RULE7
		(!rtc_n_sync && rtc_prev_reg && pg_sync && hrst_n_sync)
		|=> low_cnt_reg == 6'h00) else $error("count not restarted");
	pci_gap_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RULE7
		pci_en |=> !pci_en) else $error("pci enables back to back");
	mode_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RULE11
		!pg_sync |=> tmode_reg == PUST_TM_NONE) else $error("mode kept without power good");
	seen_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RULE11
		rtc_n_sync |=> !low_seen_reg) else $error("low pulse decoded twice");
endmodule : pust_top
`default_nettype wire

//--- sim/pust_board.sv
/*
 * board strap resistors and external test driver model.
 * assumes the bench calls pulse just after a falling clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module pust_board (
	// strap drive from bench
	input  wire logic i_tone_drv_en,
	input  wire logic i_tone_drv,
	input  wire logic i_link_drv_en,
	input  wire logic i_link_drv,
	// pins toward the block
	output logic      o_tone_pin,
	output logic      o_link_pin,
	output logic      o_batt_rst_n
);
	// undriven straps fall back to the weak pulls
	assign o_tone_pin = i_tone_drv_en ? i_tone_drv : 1'b1;
	assign o_link_pin = i_link_drv_en ? i_link_drv : 1'b0;
	initial o_batt_rst_n = 1'b1;
	// low pulse of n pci clocks plus a third, whole ref cycles long so
	// both ends fall on a falling edge like the rest of the stimulus
	task automatic pulse(input int n);
		o_batt_rst_n = 1'b0;
		#(n * 30 + 10);
		o_batt_rst_n = 1'b1;
	endtask : pulse
endmodule : pust_board
`default_nettype wire

//--- sim/tb.sv
/*
 * self-checking bench for strap capture and test-mode decode.
 * assumes pust_pkg, pust_top and pust_board are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pust_pkg::*;
	logic         ref_clk, rst, pg, host_n, tone_en, tone_d, link_en, link_d;
	logic         tone_pin, link_pin, batt_n, wd_en, safe, rel, hiz;
	logic [7:0]   d4;
	pust_straps_t straps;
	pust_tmode_t  tmode;
	int           errors, tests_run;
	int           lens[11] = '{4, 2, 5, 6, 7, 8, 9, 12, 24, 30, 3};

	pust_board board_u (.i_tone_drv_en(tone_en), .i_tone_drv(tone_d),
		.i_link_drv_en(link_en), .i_link_drv(link_d), .o_tone_pin(tone_pin),
		.o_link_pin(link_pin), .o_batt_rst_n(batt_n));
	pust_top dut_u (.i_ref_clk(ref_clk), .i_rst(rst), .i_power_good_in(pg),
		.i_tone_output_pin(tone_pin), .i_codec_link_serial_out(link_pin),
		.i_battery_well_reset_n(batt_n), .i_host_bus_reset_n(host_n),
		.o_straps(straps), .o_cfg_d4_status(d4), .o_watchdog_reboot_en(wd_en),
		.o_cpu_safe_straps(safe), .o_strap_pins_released(rel),
		.o_test_mode(tmode), .o_all_outputs_hiz(hiz));

	// 100 mhz reference
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done

	// ****************************************
	// scenarios
	// ****************************************
	// capture with pins driven, or left on the pulls when drv is low
	task automatic t_capture(input logic drv, input logic inh, input logic sm);
		int k;
		pg = 1'b0;
		tone_en = drv;
		link_en = drv;
		tone_d = ~inh;
		link_d = sm;
		cyc(16);
		check({7'h00, rel}, 8'h00);
		pg = 1'b1;
		k = 0;
		while (rel !== 1'b1 && k < 10) begin
			cyc(1);
			k++;
		end
		if (k == 10) begin
			errors++;
			test_done();
		end
		// flipped pins after capture must not reach the status
		tone_d = inh;
		link_d = ~sm;
		cyc(20);
		check({6'h00, straps}, {6'h00, inh, sm});
		check(d4, {5'h00, sm, inh, 1'b0});
		check({6'h00, wd_en, safe}, {6'h00, ~inh, sm});
		tone_en = 1'b0;
		link_en = 1'b0;
		$display("capture %b %b%b done", drv, inh, sm);
	endtask : t_capture

	// mode expected from the low-time count
	function automatic pust_tmode_t exp_mode(input int n);
		if (n >= 4 && n <= 7) return pust_tmode_t'(n - 3);
		if (n == 8) return PUST_TM_ALLZ;
		return PUST_TM_NONE;
	endfunction : exp_mode

	// host reset low for the whole pulse pauses the count
	task automatic t_tmode(input int n, input logic host_low);
		pust_tmode_t exp;
		exp = host_low ? PUST_TM_NONE : exp_mode(n);
		host_n = ~host_low;
		board_u.pulse(n);
		cyc(6);
		check({5'h00, tmode}, {5'h00, exp});
		check({7'h00, hiz}, {7'h00, exp == PUST_TM_ALLZ});
		host_n = 1'b1;
		$display("test mode %0d host %b done", n, host_low);
	endtask : t_tmode

	initial begin
		rst = 1'b1;
		pg = 1'b0;
		host_n = 1'b1;
		tone_en = 1'b0;
		tone_d = 1'b0;
		link_en = 1'b0;
		link_d = 1'b0;
		errors = 0;
		tests_run = 0;
		cyc(8);
		rst = 1'b0;
		cyc(4);
		check({3'h0, straps, wd_en, safe, rel}, 8'h04);
		check(d4, 8'h00);
		for (int i = 0; i < 4; i++) t_capture(1'b1, i[1], i[0]);
		t_capture(1'b0, 1'b0, 1'b0);
		foreach (lens[i]) t_tmode(lens[i], 1'b0);
		t_tmode(6, 1'b1);
		t_tmode(5, 1'b0);
		pg = 1'b0;
		cyc(6);
		check({5'h00, tmode}, 8'h00);
		test_done();
	end
endmodule : tb
`default_nettype wire
